// >>> src/irr_defines.svh
/*
   Constants for the interrupt request router: register offsets, source bit
   positions, reset values and line count.
   Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IRR_DEFINES_SVH
`define IRR_DEFINES_SVH

// register byte offsets
`define IRR_OFS_PEND 8'h00
`define IRR_OFS_MASK 8'h04
`define IRR_OFS_CFG0 8'h08
`define IRR_OFS_CFG1 8'h0C
`define IRR_OFS_CFG2 8'h10
`define IRR_OFS_EVT_STAT 8'h14
`define IRR_OFS_EVT_MASK 8'h18

// widths
`define IRR_NUM_SRC 32
`define IRR_NUM_LINES 5

// source bit positions
`define IRR_POS_RADIO 0
`define IRR_POS_POWER 1
`define IRR_POS_WDOG 2
`define IRR_POS_TMR1 3
`define IRR_POS_TMR0 4
`define IRR_POS_RTC 5
`define IRR_POS_UART0 6
`define IRR_POS_GPIO 7
`define IRR_POS_I2S 8
`define IRR_POS_SPI0 9
`define IRR_POS_USB 10
`define IRR_POS_I2C0 11
`define IRR_POS_I2C1 12
`define IRR_POS_VOICE 13
`define IRR_POS_AUDIO_OUT 14
`define IRR_POS_ADC 15
`define IRR_POS_UART1 16
`define IRR_POS_CARD 17
`define IRR_POS_DMA_LO 18
`define IRR_POS_DMA_HI 22
`define IRR_POS_RSVD_LO 23
`define IRR_POS_IR_RX 24
`define IRR_POS_SPI1 25
`define IRR_POS_SDIO 26
`define IRR_POS_TMR2 27
`define IRR_POS_TMR3 28
`define IRR_POS_RSVD_RW 29
`define IRR_POS_PROT 30
`define IRR_POS_RSVD_HI 31

// reset values
`define IRR_RST_WORD 32'h0000_0000
`define IRR_RST_EVT 5'h00

`endif

// >>> src/irr_pkg.sv
/*
   Types shared by the interrupt request router modules.
   Assumes irr_defines.svh is on the include path.
*/
`include "irr_defines.svh"

package irr_pkg;

   // request line codes, as formed from the three routing bits
   typedef enum logic [2:0] {
      IRR_LINE0 = 3'b000,
      IRR_LINE1 = 3'b001,
      IRR_LINE2 = 3'b010,
      IRR_LINE3 = 3'b011,
      IRR_LINE4 = 3'b100
   } irr_line_t;

   // whole state of the router top
   typedef struct packed {
      logic [`IRR_NUM_SRC-1:0] cfg0;
      logic [`IRR_NUM_SRC-1:0] cfg1;
      logic [`IRR_NUM_SRC-1:0] cfg2;
      logic [`IRR_NUM_SRC-1:0] mask;
      logic [`IRR_NUM_SRC-1:0] pend;
      logic [`IRR_NUM_LINES-1:0] req;
      logic [`IRR_NUM_LINES-1:0] evt_stat;
      logic [`IRR_NUM_LINES-1:0] evt_mask;
      logic [31:0] rd_data;
      logic irq;
   } irr_state_t;

   // one-hot request vector for a routing code
   function automatic logic [`IRR_NUM_LINES-1:0] irr_line_onehot(input logic b2, input logic b1,
                                                                 input logic b0);
      irr_line_t sel;
      sel = b2 ? IRR_LINE4 : irr_line_t'({1'b0, b1, b0});
      case (sel)
         IRR_LINE0: irr_line_onehot = 5'h01;
         IRR_LINE1: irr_line_onehot = 5'h02;
         IRR_LINE2: irr_line_onehot = 5'h04;
         IRR_LINE3: irr_line_onehot = 5'h08;
         default: irr_line_onehot = 5'h10;
      endcase
   endfunction

endpackage

// >>> src/irr_route_decode.sv
/*
   Combinational routing matrix: each active source drives the one request
   line chosen by its three routing bits.
   Assumes registered inputs; output feeds a flip-flop in the top.
*/
`timescale 1ns/100ps
`include "irr_defines.svh"

module irr_route_decode import irr_pkg::*; #(
   parameter int NUM_SRC = `IRR_NUM_SRC
) (
   // routing bits per source
   input wire logic [NUM_SRC-1:0] code_b0_in,
   input wire logic [NUM_SRC-1:0] code_b1_in,
   input wire logic [NUM_SRC-1:0] code_b2_in,
   // pending and unmasked sources
   input wire logic [NUM_SRC-1:0] active_in,
   // combined request lines
   output logic [`IRR_NUM_LINES-1:0] line_req_out
);

   logic [NUM_SRC-1:0][`IRR_NUM_LINES-1:0] hit;

   // one routing slice per source, same position in every register
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         assign hit[gi] = active_in[gi] ?
            irr_line_onehot(code_b2_in[gi], code_b1_in[gi], code_b0_in[gi]) : 5'h00;
      end
   endgenerate

   // wired-or of all slices onto the five lines
   always_comb begin
      line_req_out = 5'h00;
      for (int i = 0; i < NUM_SRC; i++) begin
         line_req_out = line_req_out | hit[i];
      end
   end

endmodule // irr_route_decode

// >>> src/irr_router.sv
/*
   Interrupt request router top: pending view, source mask, three routing
   registers, five registered request lines, and a line-edge event status
   with its own mask driving one level interrupt.
   Assumes one clock, synchronous active-high reset, peripheral pending
   levels synchronous to the clock, and a simple strobe register port
   whose master never waits.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "irr_defines.svh"

module irr_router import irr_pkg::*; (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   output logic [31:0] rd_data_out,
   // peripheral pending levels
   input wire logic [`IRR_NUM_SRC-1:0] source_pend_in,
   // processor request lines
   output logic [`IRR_NUM_LINES-1:0] req_out,
   // line-edge event interrupt
   output logic irq_out
);

   // bits that name a real source
   localparam logic [31:0] SRC_BITS =
      (32'h1 << `IRR_POS_RADIO) | (32'h1 << `IRR_POS_POWER) |
      (32'h1 << `IRR_POS_WDOG) | (32'h1 << `IRR_POS_TMR1) |
      (32'h1 << `IRR_POS_TMR0) | (32'h1 << `IRR_POS_RTC) |
      (32'h1 << `IRR_POS_GPIO) | (32'h1 << `IRR_POS_USB) |
      (32'h1 << `IRR_POS_IR_RX) | (32'h1 << `IRR_POS_SDIO) |
      (32'h1 << `IRR_POS_UART0) | (32'h1 << `IRR_POS_UART1) |
      (32'h1 << `IRR_POS_SPI0) | (32'h1 << `IRR_POS_SPI1) |
      (32'h1 << `IRR_POS_I2C0) | (32'h1 << `IRR_POS_I2C1) |
      (32'h1 << `IRR_POS_AUDIO_OUT) | (32'h1 << `IRR_POS_ADC) |
      (32'h1 << `IRR_POS_VOICE) | (32'h1 << `IRR_POS_I2S) |
      (32'h1 << `IRR_POS_CARD) | (32'h1 << `IRR_POS_TMR2) |
      (32'h1 << `IRR_POS_TMR3) | (32'h1 << `IRR_POS_PROT);

   // transfer channels occupy a contiguous run
   localparam logic [31:0] DMA_BITS =
      ((32'h1 << (`IRR_POS_DMA_HI + 1)) - 32'h1) & ~((32'h1 << `IRR_POS_DMA_LO) - 32'h1);

   // bit 29 is reserved yet keeps a plain storage cell in mask and routing
   localparam logic [31:0] RSVD_RW = 32'h1 << `IRR_POS_RSVD_RW;

   // writable bits; 23 and 31 never store, so they read zero
   localparam logic [31:0] WR_MASK = SRC_BITS | DMA_BITS | RSVD_RW;

   // pending view carries sources only
   localparam logic [31:0] PEND_MASK = SRC_BITS | DMA_BITS;

   irr_state_t state_r;
   irr_state_t state_nxt;
   logic [`IRR_NUM_LINES-1:0] line_req;
   logic [`IRR_NUM_SRC-1:0] active;

   // address match for writes, one function for all registers
   function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
      wr_hit = stb && (a == ofs);
   endfunction

   // a source reaches the matrix only when pending and unmasked
   assign active = state_r.pend & state_r.mask;

   // routing matrix
   irr_route_decode #(
      .NUM_SRC(`IRR_NUM_SRC)
   ) u_decode (
      .code_b0_in(state_r.cfg0),
      .code_b1_in(state_r.cfg1),
      .code_b2_in(state_r.cfg2),
      .active_in(active),
      .line_req_out(line_req)
   );

   // next-state logic
   always_comb begin
      logic [`IRR_NUM_LINES-1:0] rise;
      logic [`IRR_NUM_LINES-1:0] clr;
      rise = 5'h00;
      clr = 5'h00;
      state_nxt = state_r;

      // pending follows the peripheral levels; no write path reaches it
      state_nxt.pend = source_pend_in & PEND_MASK;

      // request lines registered so every output comes from a flop
      state_nxt.req = line_req;

      // routing and mask writes, reserved bits 23 and 31 dropped
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_CFG0)) begin
         state_nxt.cfg0 = wr_data_in & WR_MASK;
      end
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_CFG1)) begin
         state_nxt.cfg1 = wr_data_in & WR_MASK;
      end
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_CFG2)) begin
         state_nxt.cfg2 = wr_data_in & WR_MASK;
      end
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_MASK)) begin
         state_nxt.mask = wr_data_in & WR_MASK;
      end
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_EVT_MASK)) begin
         state_nxt.evt_mask = wr_data_in[`IRR_NUM_LINES-1:0];
      end

      // line rising edges are events; a new edge beats a same-cycle clear
      rise = line_req & ~state_r.req;
      if (wr_hit(wr_stb_in, addr_in, `IRR_OFS_EVT_STAT)) begin
         clr = wr_data_in[`IRR_NUM_LINES-1:0];
      end
      state_nxt.evt_stat = (state_r.evt_stat & ~clr) | rise;

      // level interrupt from the registered status, one cycle behind it
      state_nxt.irq = |(state_r.evt_stat & state_r.evt_mask);

      // read data valid only in the cycle after the strobe
      state_nxt.rd_data = 32'h0000_0000;
      if (rd_stb_in) begin
         case (addr_in)
            `IRR_OFS_PEND: state_nxt.rd_data = state_r.pend;
            `IRR_OFS_MASK: state_nxt.rd_data = state_r.mask;
            `IRR_OFS_CFG0: state_nxt.rd_data = state_r.cfg0;
            `IRR_OFS_CFG1: state_nxt.rd_data = state_r.cfg1;
            `IRR_OFS_CFG2: state_nxt.rd_data = state_r.cfg2;
            `IRR_OFS_EVT_STAT: state_nxt.rd_data = {27'h0000000, state_r.evt_stat};
            `IRR_OFS_EVT_MASK: state_nxt.rd_data = {27'h0000000, state_r.evt_mask};
            default: state_nxt.rd_data = 32'h0000_0000;
         endcase
      end
   end

   // state register; reset routes everything to line 0
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_r.cfg0 <= `IRR_RST_WORD;
         state_r.cfg1 <= `IRR_RST_WORD;
         state_r.cfg2 <= `IRR_RST_WORD;
         state_r.mask <= `IRR_RST_WORD;
         state_r.pend <= `IRR_RST_WORD;
         state_r.req <= `IRR_RST_EVT;
         state_r.evt_stat <= `IRR_RST_EVT;
         state_r.evt_mask <= `IRR_RST_EVT;
         state_r.rd_data <= `IRR_RST_WORD;
         state_r.irq <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from the state flops
   assign rd_data_out = state_r.rd_data;
   assign req_out = state_r.req;
   assign irq_out = state_r.irq;

   // checks, all in the system clock domain
   default clocking cb_sys @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   // a fully masked controller never raises a line
   AST_MASK_BLOCKS: assert property (
      (state_r.mask == 32'h0000_0000) |=> (req_out == 5'h00))
      else $error("line raised while every source masked");

   // a source with routing bit 2 set lands on line 4
   AST_CODE_FOUR: assert property (
      (active[`IRR_POS_RADIO] && state_r.cfg2[`IRR_POS_RADIO]) |=> req_out[4])
      else $error("code with bit 2 set did not reach line 4");

   // code 011 lands on line 3
   AST_CODE_THREE: assert property (
      (active[`IRR_POS_RTC] && !state_r.cfg2[`IRR_POS_RTC] && state_r.cfg1[`IRR_POS_RTC]
       && state_r.cfg0[`IRR_POS_RTC]) |=> req_out[3])
      else $error("code 011 did not reach line 3");

   // code 000 lands on line 0
   AST_CODE_ZERO: assert property (
      (active[`IRR_POS_CARD] && state_r.cfg2[`IRR_POS_CARD] == 1'b0 && state_r.cfg1[`IRR_POS_CARD] == 1'b0
       && state_r.cfg0[`IRR_POS_CARD] == 1'b0) |=> req_out[0])
      else $error("code 000 did not reach line 0");

   // lines are quiet exactly when nothing is pending and unmasked
   AST_LINES_QUIET: assert property (
      (active == 32'h0000_0000) |=> (req_out == 5'h00))
      else $error("line high with no active source");

   AST_LINES_BUSY: assert property (
      (active != 32'h0000_0000) |=> (req_out != 5'h00))
      else $error("active source but every line low");

   // routing write stores the writable bits, reserved 23 stays zero
   AST_CFG_WRITE: assert property (
      (wr_stb_in && addr_in == `IRR_OFS_CFG1) |=>
         (state_r.cfg1 == ($past(wr_data_in) & WR_MASK)) && (state_r.cfg1[`IRR_POS_RSVD_LO] == 1'b0))
      else $error("routing write stored wrong value");

   // routing readback a cycle after the strobe, then gone
   AST_CFG_READ: assert property (
      (rd_stb_in && addr_in == `IRR_OFS_CFG2 && !wr_stb_in) |=>
         (rd_data_out == $past(state_r.cfg2)) ##1 ($past(rd_stb_in) || rd_data_out == 32'h0000_0000))
      else $error("routing readback wrong or held too long");

   // writing the pending view changes nothing of it
   AST_PEND_FOLLOW: assert property (
      (wr_stb_in && addr_in == `IRR_OFS_PEND) |=> (state_r.pend == ($past(source_pend_in) & PEND_MASK)))
      else $error("pending view disturbed by a write");

   // a new line edge survives a same-cycle clear
   AST_SET_WINS: assert property (
      (line_req[0] && !state_r.req[0] && wr_stb_in && addr_in == `IRR_OFS_EVT_STAT && wr_data_in[0])
      |=> state_r.evt_stat[0])
      else $error("event lost to a same-cycle clear");

   // unmasked status raises the interrupt one cycle later
   AST_IRQ_LEVEL: assert property (
      ((state_r.evt_stat & state_r.evt_mask) != 5'h00) |=> irq_out)
      else $error("interrupt low with unmasked event");

   // code 001 lands on line 1
   AST_CODE_ONE: assert property (
      (active[`IRR_POS_TMR1] && !state_r.cfg2[`IRR_POS_TMR1] && !state_r.cfg1[`IRR_POS_TMR1]
       && state_r.cfg0[`IRR_POS_TMR1]) |=> req_out[1])
      else $error("code 001 did not reach line 1");

   // code 010 lands on line 2
   AST_CODE_TWO: assert property (
      (active[`IRR_POS_UART0] && !state_r.cfg2[`IRR_POS_UART0] && state_r.cfg1[`IRR_POS_UART0]
       && !state_r.cfg0[`IRR_POS_UART0]) |=> req_out[2])
      else $error("code 010 did not reach line 2");

   // one active source drives exactly one line
   AST_ONE_LINE: assert property (
      $onehot(active) |=> $onehot(req_out))
      else $error("single source drove other than one line");

   // all-zero codes put every active source on line 0 alone
   AST_ALL_LINE0: assert property (
      ((active != 32'h0000_0000)
       && ((active & (state_r.cfg0 | state_r.cfg1 | state_r.cfg2)) == 32'h0000_0000)) |=> (req_out == 5'h01))
      else $error("zero codes did not land on line 0 alone");

   // reset leaves routing at line 0 for every source
   AST_RESET_ROUTE: assert property (
      $fell(sys_rst_in) |-> ((state_r.cfg0 | state_r.cfg1 | state_r.cfg2) == 32'h0000_0000))
      else $error("routing not cleared by reset");

   // reset leaves mask, events and outputs quiet
   AST_RESET_OUT: assert property (
      $fell(sys_rst_in) |-> (state_r.mask == 32'h0000_0000 && state_r.evt_stat == 5'h00
       && state_r.evt_mask == 5'h00 && req_out == 5'h00 && !irq_out && rd_data_out == 32'h0000_0000))
      else $error("state not cleared by reset");

   // reserved positions 23 and 31 never hold a one
   AST_RSVD_ZERO: assert property (
      !(state_r.cfg0[`IRR_POS_RSVD_LO] || state_r.cfg1[`IRR_POS_RSVD_LO] || state_r.cfg2[`IRR_POS_RSVD_LO]
        || state_r.cfg0[`IRR_POS_RSVD_HI] || state_r.mask[`IRR_POS_RSVD_LO]))
      else $error("reserved routing bit stored a one");

   // reserved positions 23 and 31 read back as zero
   AST_RSVD_READ: assert property (
      (rd_stb_in && addr_in == `IRR_OFS_CFG1) |=>
         (!rd_data_out[`IRR_POS_RSVD_LO] && !rd_data_out[`IRR_POS_RSVD_HI]))
      else $error("reserved routing bit read as one");

   // pending view never shows a reserved position
   AST_PEND_RSVD: assert property (
      !(state_r.pend[`IRR_POS_RSVD_LO] || state_r.pend[`IRR_POS_RSVD_RW] || state_r.pend[`IRR_POS_RSVD_HI]))
      else $error("pending view set at a reserved bit");

   // pending view is the peripheral level one edge later
   AST_PEND_TRACK: assert property (
      1'b1 |=> (state_r.pend == ($past(source_pend_in) & PEND_MASK)))
      else $error("pending view lost the peripheral level");

   // routing bit 0 write stores the writable bits
   AST_CFG0_WRITE: assert property (
      (wr_stb_in && addr_in == `IRR_OFS_CFG0) |=> (state_r.cfg0 == ($past(wr_data_in) & WR_MASK)))
      else $error("routing bit 0 write stored wrong value");

   // mask write stores the writable bits
   AST_MASK_WRITE: assert property (
      (wr_stb_in && addr_in == `IRR_OFS_MASK) |=> (state_r.mask == ($past(wr_data_in) & WR_MASK)))
      else $error("mask write stored wrong value");

   // routing holds unless its own offset is written
   AST_CFG_HOLD: assert property (
      !(wr_stb_in && addr_in == `IRR_OFS_CFG0) |=> $stable(state_r.cfg0))
      else $error("routing bit 0 changed without a write");

   // read data idle at zero after a cycle with no read
   AST_READ_IDLE: assert property (
      !rd_stb_in |=> (rd_data_out == 32'h0000_0000))
      else $error("read data not zero after an idle cycle");

   // mask readback
   AST_READ_MASK: assert property (
      (rd_stb_in && addr_in == `IRR_OFS_MASK) |=> (rd_data_out == $past(state_r.mask)))
      else $error("mask readback wrong");

   // pending readback
   AST_READ_PEND: assert property (
      (rd_stb_in && addr_in == `IRR_OFS_PEND) |=> (rd_data_out == $past(state_r.pend)))
      else $error("pending readback wrong");

   // offsets past the event mask read zero
   AST_READ_UNMAPPED: assert property (
      (rd_stb_in && addr_in > `IRR_OFS_EVT_MASK) |=> (rd_data_out == 32'h0000_0000))
      else $error("unmapped offset read nonzero");

   // a line rise always lands in the status
   AST_EVT_SET: assert property (
      ((line_req & ~state_r.req) != 5'h00) |=>
         ((state_r.evt_stat & $past(line_req & ~state_r.req)) == $past(line_req & ~state_r.req)))
      else $error("line rise missing from event status");

   // write-one clears a status bit when no rise competes
   AST_EVT_CLEAR: assert property (
      (wr_stb_in && addr_in == `IRR_OFS_EVT_STAT && wr_data_in[0] && !(line_req[0] && !state_r.req[0]))
      |=> !state_r.evt_stat[0])
      else $error("event status bit survived its clear");

   // interrupt stays low without an unmasked event
   AST_IRQ_QUIET: assert property (
      ((state_r.evt_stat & state_r.evt_mask) == 5'h00) |=> !irq_out)
      else $error("interrupt high without unmasked event");

   // transfer channel 4 alone on code 011
   AST_POS_DMA: assert property (
      ((active == (32'h1 << `IRR_POS_DMA_HI)) && !state_r.cfg2[`IRR_POS_DMA_HI]
       && state_r.cfg1[`IRR_POS_DMA_HI] && state_r.cfg0[`IRR_POS_DMA_HI]) |=> (req_out == 5'h08))
      else $error("transfer channel 4 misrouted");

   // second serial port alone on code 1xx, low bits ignored
   AST_POS_SERIAL: assert property (
      ((active == (32'h1 << `IRR_POS_SPI1)) && state_r.cfg2[`IRR_POS_SPI1]) |=> (req_out == 5'h10))
      else $error("serial source misrouted");

   // voice detector alone on code 001
   AST_POS_AUDIO: assert property (
      ((active == (32'h1 << `IRR_POS_VOICE)) && !state_r.cfg2[`IRR_POS_VOICE]
       && !state_r.cfg1[`IRR_POS_VOICE] && state_r.cfg0[`IRR_POS_VOICE]) |=> (req_out == 5'h02))
      else $error("audio source misrouted");

   // card data port alone on code 010
   AST_POS_SYSTEM: assert property (
      ((active == (32'h1 << `IRR_POS_SDIO)) && !state_r.cfg2[`IRR_POS_SDIO]
       && state_r.cfg1[`IRR_POS_SDIO] && !state_r.cfg0[`IRR_POS_SDIO]) |=> (req_out == 5'h04))
      else $error("system source misrouted");

endmodule // irr_router

// >>> testbench/irr_cpu_model.sv
/*
   Processor-side stand-in for the router: samples the five request lines
   and counts rising edges over all of them.
   Assumes the lines are synchronous to the system clock.
*/
`timescale 1ns/100ps
`include "irr_defines.svh"

module irr_cpu_model import irr_pkg::*; (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // request lines from the router
   input wire logic [`IRR_NUM_LINES-1:0] req_in,
   // rises seen on any line
   output logic [15:0] rise_total_out
);
   logic [`IRR_NUM_LINES-1:0] seen_r;

   // a core only notices a line on its own clock edge, so sample there
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         seen_r <= '0;
         rise_total_out <= '0;
      end else begin
         seen_r <= req_in;
         rise_total_out <= rise_total_out + 16'($countones(req_in & ~seen_r));
      end
   end
endmodule // irr_cpu_model

// >>> testbench/test_interrupt_request_router.sv
/*
   Self-checking bench for the router: register port, random routing,
   mask, pending view and line-edge events.
   Assumes the register port never waits and read data follow by one cycle.
*/
`timescale 1ns/100ps
`include "irr_defines.svh"

module test_interrupt_request_router import irr_pkg::*; ;
   localparam logic [31:0] RW_BITS = 32'h7F7F_FFFF; // 23 and 31 never store
   localparam logic [31:0] SRC_BITS = 32'h5F7F_FFFF; // holes at 23, 29, 31
   localparam int LIMIT = 5000;
   logic clk_sys_in, sys_rst_in, wr_stb_in, rd_stb_in, rd_seen, probe_r, irq_out;
   logic [7:0] addr_in;
   logic [31:0] wr_data_in, rd_data_out, source_pend_in;
   logic [4:0] req_out;
   logic [15:0] rise_total;
   logic [15:0] lfsr_r = 16'hCCED;
   logic [31:0] rq[$];
   logic [5:0] lq[$];
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   irr_router dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .rd_data_out(rd_data_out),
      .source_pend_in(source_pend_in), .req_out(req_out), .irq_out(irq_out));
   irr_cpu_model cpu_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req_out),
      .rise_total_out(rise_total));

   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   // 16-bit shift register, two steps per word
   function automatic logic [31:0] rnd32();
      logic [31:0] v;
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v[15:0] = lfsr_r;
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v[31:16] = lfsr_r ^ {lfsr_r[7:0], lfsr_r[15:8]};
      return v;
   endfunction

   function automatic logic [4:0] route(input logic [31:0] c0, c1, c2, act);
      route = '0;
      for (int i = 0; i < 32; i++) begin
         if (act[i] && c2[i]) route[4] = 1'b1;
         else if (act[i]) route[{c1[i], c0[i]}] = 1'b1;
      end
   endfunction

   task automatic fail(input string what, input logic [31:0] got, exp);
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_stb_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_stb_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_stb_in <= 1'b1;
      rq.push_back(e);
      @(posedge clk_sys_in);
      rd_stb_in <= 1'b0;
   endtask

   // lines settle two edges after a change, one spare edge on top
   task automatic probe(input logic [5:0] e);
      repeat (3) @(posedge clk_sys_in);
      probe_r <= 1'b1;
      lq.push_back(e);
      @(posedge clk_sys_in);
      probe_r <= 1'b0;
   endtask

   task automatic drive_src(input logic [31:0] p);
      @(posedge clk_sys_in);
      source_pend_in <= p;
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // results are compared between edges, when they have settled
   always @(posedge clk_sys_in) rd_seen <= rd_stb_in;
   always @(negedge clk_sys_in) begin
      if (rd_seen === 1'b1) begin
         checks++;
         if (rd_data_out !== rq[0]) fail("read", rd_data_out, rq[0]);
         void'(rq.pop_front());
      end
      if (probe_r === 1'b1) begin
         checks++;
         if ({irq_out, req_out} !== lq[0]) fail("lines", 32'({irq_out, req_out}), 32'(lq[0]));
         void'(lq.pop_front());
      end
   end

   // hang guard
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail("timeout", 32'(cycles), 32'(LIMIT));
         summarize();
      end
   end

   initial begin
      logic [31:0] c0, c1, c2, m, p, t;
      logic [15:0] r0;
      sys_rst_in = 1'b1;
      wr_stb_in = 1'b0;
      rd_stb_in = 1'b0;
      probe_r = 1'b0;
      addr_in = 8'h00;
      wr_data_in = 32'h0;
      source_pend_in = 32'h0;
      repeat (12) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      for (int a = 0; a <= 8'h1C; a += 4) rd(8'(a), 32'h0);
      probe(6'h00);
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         c0 = rnd32();
         wr(8'h08 + 8'(4 * k), c0 | 32'h0002_0000);
         rd(8'h08 + 8'(4 * k), (c0 | 32'h0002_0000) & RW_BITS);
      end
      wr(`IRR_OFS_MASK, 32'hFFFF_FFFF);
      rd(`IRR_OFS_MASK, RW_BITS);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0);
      $display("test registers done");
      for (int n = 0; n < 40; n++) begin
         c0 = rnd32();
         c1 = rnd32();
         c2 = rnd32();
         m = rnd32();
         p = rnd32();
         t = rnd32();
         p = p & t;
         t = rnd32();
         p = p & t;
         wr(`IRR_OFS_CFG0, c0);
         wr(`IRR_OFS_CFG1, c1);
         wr(`IRR_OFS_CFG2, c2);
         wr(`IRR_OFS_MASK, m);
         drive_src(p);
         probe({1'b0, route(c0, c1, c2, p & m & SRC_BITS)});
         rd(`IRR_OFS_PEND, p & SRC_BITS);
      end
      wr(`IRR_OFS_PEND, 32'h0);
      rd(`IRR_OFS_PEND, p & SRC_BITS);
      wr(`IRR_OFS_MASK, 32'h0);
      drive_src(32'hFFFF_FFFF);
      probe(6'h00);
      $display("test routing done");
      drive_src(32'h0);
      wr(`IRR_OFS_CFG0, 32'h0);
      wr(`IRR_OFS_CFG1, 32'h0);
      wr(`IRR_OFS_CFG2, 32'h0);
      wr(`IRR_OFS_MASK, 32'h20);
      wr(`IRR_OFS_EVT_MASK, 32'h1F);
      wr(`IRR_OFS_EVT_STAT, 32'h1F);
      rd(`IRR_OFS_EVT_STAT, 32'h0);
      r0 = rise_total;
      drive_src(32'h20);
      probe(6'h21);
      rd(`IRR_OFS_EVT_STAT, 32'h1);
      wr(`IRR_OFS_EVT_STAT, 32'h1);
      probe(6'h01);
      checks++;
      if (rise_total !== r0 + 16'd1) fail("rises", 32'(rise_total), 32'(r0 + 16'd1));
      wr(`IRR_OFS_EVT_MASK, 32'h0);
      drive_src(32'h0);
      probe(6'h00);
      drive_src(32'h20);
      probe(6'h01);
      rd(`IRR_OFS_EVT_STAT, 32'h1);
      // clear the held event, drop the line, then clear on the very edge it rises: the rise must survive
      wr(`IRR_OFS_EVT_STAT, 32'h1);
      drive_src(32'h0);
      probe(6'h00);
      drive_src(32'h20);
      wr(`IRR_OFS_EVT_STAT, 32'h1);
      rd(`IRR_OFS_EVT_STAT, 32'h1);
      $display("test events done");
      repeat (3) @(posedge clk_sys_in);
      summarize();
   end
endmodule // test_interrupt_request_router
